// ===== verilog/dmarc_pkg.sv
// Constants shared by the two-channel DMA request, mask and interrupt control block
package dmarc_pkg;
    // ========================================
    // Sizes
    localparam int NUM_CH = 2;
    localparam int DW = 8;
    localparam int AW = 16;
    // ========================================
    // I/O addresses, expanded space
    localparam logic [AW-1:0] ADDR_SOFT_REQ = 16'hF009;
    localparam logic [AW-1:0] ADDR_CH_MASK = 16'hF00A;
    localparam logic [AW-1:0] ADDR_CLR_BPTR = 16'hF00C;
    localparam logic [AW-1:0] ADDR_MCLR = 16'hF00D;
    localparam logic [AW-1:0] ADDR_CLR_MASKS = 16'hF00E;
    localparam logic [AW-1:0] ADDR_GRP_MASK = 16'hF00F;
    localparam logic [AW-1:0] ADDR_BUS_WIDTH = 16'hF018;
    localparam logic [AW-1:0] ADDR_CHAIN = 16'hF019;
    localparam logic [AW-1:0] ADDR_IRQ_EN = 16'hF01C;
    localparam logic [AW-1:0] ADDR_CLR_DONE = 16'hF01E;
    // ========================================
    // I/O addresses, compatible space aliases
    localparam logic [AW-1:0] ISA_SOFT_REQ = 16'h0009;
    localparam logic [AW-1:0] ISA_CH_MASK = 16'h000A;
    localparam logic [AW-1:0] ISA_CLR_BPTR = 16'h000C;
    localparam logic [AW-1:0] ISA_MCLR = 16'h000D;
    localparam logic [AW-1:0] ISA_CLR_MASKS = 16'h000E;
    localparam logic [AW-1:0] ISA_GRP_MASK = 16'h000F;
    // ========================================
    // Field positions
    localparam int BIT_CH_SEL = 0;
    localparam int BIT_SET = 2;
    localparam int BIT_TGT_W = 4;
    localparam int BIT_REQ_W = 6;
    localparam int IS_CHAIN_LSB = 0;
    localparam int IS_DONE_LSB = 4;
    // ========================================
    // Reset values
    localparam logic [NUM_CH-1:0] RST_PENDING = 2'h0;
    localparam logic [NUM_CH-1:0] RST_MASK = 2'h3;
    localparam logic [NUM_CH-1:0] RST_IRQ_EN = 2'h0;
    localparam logic RST_WIDTH_8 = 1'h1;
    localparam logic RST_CHAIN = 1'h0;
    localparam logic [DW-1:0] RDATA_NONE = 8'h00;
endpackage : dmarc_pkg

// ===== verilog/dmarc_chan_if.sv
// Per-channel command and state bundle between the decoder and a channel slice
`timescale 1ns/1ps
interface dmarc_chan_if;
    logic mclr; // Master clear pulse
    logic soft_set; // Software request write with set bit
    logic mask_wr; // Single-channel mask write
    logic grp_wr; // Group mask write
    logic clr_masks; // Clear-all-masks command
    logic width_wr; // Bus size write
    logic chain_wr; // Chaining write
    logic wval; // Mask or chain value written
    logic req8_val; // Requester width value
    logic tgt8_val; // Target width value
    logic done; // Buffer transfer completed
    logic clr_soft; // Clear pending request from auto-init event
    logic auto_init; // Channel in auto-initialize mode
    logic irq_en; // Completion interrupt enable
    logic need; // Channel needs new transfer information
    logic tgt_msb_wr; // Target address top byte written
    logic done_clr; // Clear completion status
    logic pending; // Pending software request
    logic mask; // Hardware request mask
    logic req8; // Requester width is 8 bits
    logic tgt8; // Target width is 8 bits
    logic chain; // Chaining enabled
    logic done_st; // Completion interrupt status
    logic chain_st; // Chaining interrupt status
    modport ctl (output mclr, soft_set, mask_wr, grp_wr, clr_masks, width_wr, chain_wr,
        wval, req8_val, tgt8_val, done, clr_soft, auto_init, irq_en, need, tgt_msb_wr,
        done_clr, input pending, mask, req8, tgt8, chain, done_st, chain_st);
    modport chan (input mclr, soft_set, mask_wr, grp_wr, clr_masks, width_wr, chain_wr,
        wval, req8_val, tgt8_val, done, clr_soft, auto_init, irq_en, need, tgt_msb_wr,
        done_clr, output pending, mask, req8, tgt8, chain, done_st, chain_st);
endinterface : dmarc_chan_if

// ===== verilog/dmarc_channel.sv
// State of one DMA channel: pending request, mask, widths, chaining and status flags
`timescale 1ns/1ps
module dmarc_channel
    import dmarc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    dmarc_chan_if.chan bus
);
    // ========================================
    // Local state
    logic rst; // Reset or master clear
    assign rst = !i_reset_n || bus.mclr;

    // Pending software request, set wins over completion
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.pending <= 1'h0;
        end else if (bus.soft_set) begin
            bus.pending <= 1'h1;
        end else if (bus.done || bus.clr_soft) begin
            bus.pending <= 1'h0;
        end
    end

    // Hardware request mask, shared by every mask path
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.mask <= 1'h1;
        end else if (bus.done && !bus.auto_init) begin
            bus.mask <= 1'h1;
        end else if (bus.mask_wr || bus.grp_wr) begin
            bus.mask <= bus.wval;
        end else if (bus.clr_masks) begin
            bus.mask <= 1'h0;
        end
    end

    // Bus widths, 1 selects 8 bits
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.req8 <= RST_WIDTH_8;
            bus.tgt8 <= RST_WIDTH_8;
        end else if (bus.width_wr) begin
            bus.req8 <= bus.req8_val;
            bus.tgt8 <= bus.tgt8_val;
        end
    end

    // Chaining enable
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.chain <= RST_CHAIN;
        end else if (bus.chain_wr) begin
            bus.chain <= bus.wval;
        end
    end

    // Completion status: only when enabled and not chaining; set wins over clear
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.done_st <= 1'h0;
        end else if (bus.done && bus.irq_en && !bus.chain) begin
            bus.done_st <= 1'h1;
        end else if (bus.done_clr) begin
            bus.done_st <= 1'h0;
        end
    end

    // Chaining status: set on need, cleared by top target byte write
    always_ff @(posedge i_clk) begin
        if (rst) begin
            bus.chain_st <= 1'h0;
        end else if (bus.need && bus.chain) begin
            bus.chain_st <= 1'h1;
        end else if (bus.tgt_msb_wr) begin
            bus.chain_st <= 1'h0;
        end
    end
endmodule : dmarc_channel

// ===== verilog/dmarc_ctrl.sv
// I/O decode, channel slices, read-back and interrupt output of the DMA request control
`timescale 1ns/1ps
// Notes on behaviour
// - Pending request read: bit1 ch1, bit0 ch0
// - Completion or end-of-process clears channel's pending
// - Auto-init completion clears both pending flags
// - Non-auto-init end-of-process sets channel's mask
// - Single mask write: bit0 channel, bit2 value
// - Group mask read/write, both set at reset
// - Masked channel still services software requests
// - Bus size write: bit6 requester, bit4 target
// - Chaining write: bit2 enables chaining, interrupt too
// - Chaining interrupt whenever a chaining-enabled channel needs new info
// - Interrupt enable gates completion onto output
// - Chaining makes completion enable have no effect
// - Status: completion bits 5,4; chaining 1,0
// - Completion status needs enable; cleared by status read
// - Chaining status set when new info needed
// - Chaining status cleared by top target byte
// - Commands act on any write, data ignored
// - Clear-byte-pointer command resets byte pointer
// - Master clear returns everything to defaults
// - Clear masks both; clear-done drops interrupt
// - Software request held until buffer completes
module dmarc_ctrl
    import dmarc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [AW-1:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [DW-1:0] i_io_wdata,
    output logic [DW-1:0] o_io_rdata,
    input wire logic [NUM_CH-1:0] i_channel_hw_request,
    input wire logic [NUM_CH-1:0] i_term_count,
    input wire logic [NUM_CH-1:0] i_end_of_process_n,
    input wire logic [NUM_CH-1:0] i_auto_init,
    input wire logic [NUM_CH-1:0] i_chain_need,
    input wire logic [NUM_CH-1:0] i_tgt_msb_wr,
    input wire logic i_main_status_rd,
    output logic [NUM_CH-1:0] o_hw_request,
    output logic [NUM_CH-1:0] o_soft_request,
    output logic [NUM_CH-1:0] o_hw_mask,
    output logic [NUM_CH-1:0] o_req_width_8,
    output logic [NUM_CH-1:0] o_tgt_width_8,
    output logic [NUM_CH-1:0] o_chain_en,
    output logic o_clear_byte_ptr,
    output logic o_master_clear,
    output logic o_dma_irq_out
);
    // ========================================
    // Address decode helper
    // True when the address matches either of two aliases
    function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] e,
        input logic [AW-1:0] s);
        addr_hit = (a == e) || (a == s);
    endfunction : addr_hit

    // ========================================
    // Write strobes
    logic wr_soft; // Software request write
    logic wr_mask; // Single-channel mask write
    logic wr_grp; // Group mask write
    logic wr_width; // Bus size write
    logic wr_chain; // Chaining write
    logic wr_ien; // Interrupt enable write
    logic cmd_bptr; // Clear byte pointer command
    logic cmd_mclr; // Master clear command
    logic cmd_masks; // Clear all masks command
    logic cmd_done; // Clear transfer complete command
    logic ch_sel; // Channel chosen by bit 0

    // Decode writes; command strobes ignore the data
    always_comb begin
        wr_soft = i_io_wr && addr_hit(i_io_addr, ADDR_SOFT_REQ, ISA_SOFT_REQ);
        wr_mask = i_io_wr && addr_hit(i_io_addr, ADDR_CH_MASK, ISA_CH_MASK);
        wr_grp = i_io_wr && addr_hit(i_io_addr, ADDR_GRP_MASK, ISA_GRP_MASK);
        wr_width = i_io_wr && addr_hit(i_io_addr, ADDR_BUS_WIDTH, ADDR_BUS_WIDTH);
        wr_chain = i_io_wr && addr_hit(i_io_addr, ADDR_CHAIN, ADDR_CHAIN);
        wr_ien = i_io_wr && addr_hit(i_io_addr, ADDR_IRQ_EN, ADDR_IRQ_EN);
        cmd_bptr = i_io_wr && addr_hit(i_io_addr, ADDR_CLR_BPTR, ISA_CLR_BPTR);
        cmd_mclr = i_io_wr && addr_hit(i_io_addr, ADDR_MCLR, ISA_MCLR);
        cmd_masks = i_io_wr && addr_hit(i_io_addr, ADDR_CLR_MASKS, ISA_CLR_MASKS);
        cmd_done = i_io_wr && addr_hit(i_io_addr, ADDR_CLR_DONE, ADDR_CLR_DONE);
        ch_sel = i_io_wdata[BIT_CH_SEL];
    end

    // Command pulses to the transfer engine
    assign o_clear_byte_ptr = cmd_bptr;
    assign o_master_clear = cmd_mclr;

    // ========================================
    // End-of-process edge detect
    logic [NUM_CH-1:0] eop_n_q; // Last sampled end-of-process level
    logic [NUM_CH-1:0] eop_evt; // Falling edge of end-of-process
    logic [NUM_CH-1:0] done; // Terminal count or end-of-process
    logic clr_all_soft; // Auto-init completion clears both requests

    // Remember the previous end-of-process level
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            eop_n_q <= '1;
        end else begin
            eop_n_q <= i_end_of_process_n;
        end
    end

    // Completion events per channel
    always_comb begin
        eop_evt = eop_n_q & ~i_end_of_process_n;
        done = i_term_count | eop_evt;
        clr_all_soft = |(done & i_auto_init);
    end

    // ========================================
    // Interrupt enable register
    logic [NUM_CH-1:0] irq_en_q; // Completion interrupt enables

    // Read/write enable bits, cleared by master clear
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || cmd_mclr) begin
            irq_en_q <= RST_IRQ_EN;
        end else if (wr_ien) begin
            irq_en_q <= i_io_wdata[NUM_CH-1:0];
        end
    end

    // ========================================
    // Channel slices
    logic [NUM_CH-1:0] pending; // Pending software requests
    logic [NUM_CH-1:0] mask; // Hardware request masks
    logic [NUM_CH-1:0] done_st; // Completion statuses
    logic [NUM_CH-1:0] chain_st; // Chaining statuses

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            dmarc_chan_if u_if();
            // Route strobes for channel c
            assign u_if.mclr = cmd_mclr;
            assign u_if.soft_set = wr_soft && (ch_sel == c[0]) && i_io_wdata[BIT_SET];
            assign u_if.mask_wr = wr_mask && (ch_sel == c[0]);
            assign u_if.grp_wr = wr_grp;
            assign u_if.clr_masks = cmd_masks;
            assign u_if.width_wr = wr_width && (ch_sel == c[0]);
            assign u_if.chain_wr = wr_chain && (ch_sel == c[0]);
            assign u_if.wval = wr_grp ? i_io_wdata[c] : i_io_wdata[BIT_SET];
            assign u_if.req8_val = i_io_wdata[BIT_REQ_W];
            assign u_if.tgt8_val = i_io_wdata[BIT_TGT_W];
            assign u_if.done = done[c];
            assign u_if.clr_soft = clr_all_soft;
            assign u_if.auto_init = i_auto_init[c];
            assign u_if.irq_en = irq_en_q[c];
            assign u_if.need = i_chain_need[c];
            assign u_if.tgt_msb_wr = i_tgt_msb_wr[c];
            assign u_if.done_clr = i_main_status_rd || cmd_done;
            // Collect the state
            assign pending[c] = u_if.pending;
            assign mask[c] = u_if.mask;
            assign o_req_width_8[c] = u_if.req8;
            assign o_tgt_width_8[c] = u_if.tgt8;
            assign o_chain_en[c] = u_if.chain;
            assign done_st[c] = u_if.done_st;
            assign chain_st[c] = u_if.chain_st;
            dmarc_channel u_chan (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .bus(u_if.chan)
            );
        end
    endgenerate

    // Requests to the arbiter; a mask never blocks the software path
    assign o_hw_request = i_channel_hw_request & ~mask;
    assign o_soft_request = pending;
    assign o_hw_mask = mask;

    // Interrupt output: completion or active chaining status
    assign o_dma_irq_out = (|done_st) || (|(chain_st & o_chain_en));

    // ========================================
    // Read-back
    logic [DW-1:0] rdata_q; // Registered read data

    // Register the selected read value; unmapped reads return zero
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_q <= RDATA_NONE;
        end else if (!i_io_rd) begin
            rdata_q <= RDATA_NONE;
        end else if (addr_hit(i_io_addr, ADDR_SOFT_REQ, ISA_SOFT_REQ)) begin
            rdata_q <= {6'h00, pending};
        end else if (addr_hit(i_io_addr, ADDR_GRP_MASK, ISA_GRP_MASK)) begin
            rdata_q <= {6'h00, mask};
        end else if (addr_hit(i_io_addr, ADDR_CHAIN, ADDR_CHAIN)) begin
            rdata_q <= {2'h0, done_st, 2'h0, chain_st};
        end else if (addr_hit(i_io_addr, ADDR_IRQ_EN, ADDR_IRQ_EN)) begin
            rdata_q <= {6'h00, irq_en_q};
        end else begin
            rdata_q <= RDATA_NONE;
        end
    end
    assign o_io_rdata = rdata_q;

    // ========================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_soft_wr0;
        wr_soft && !i_io_wdata[BIT_CH_SEL] && i_io_wdata[BIT_SET] && !cmd_mclr;
    endsequence
    sequence s_done0_quiet;
        done[0] && !wr_soft && !cmd_mclr;
    endsequence

    soft_req_set_a: assert property (s_soft_wr0 |=> pending[0] && o_soft_request[0])
        else $error("software request not raised");
    done_clears_a: assert property (s_done0_quiet |=> !pending[0])
        else $error("pending request survived completion");
    auto_clear_both_a: assert property ((done[0] && i_auto_init[0] && !wr_soft && !cmd_mclr)
        |=> pending == 2'h0)
        else $error("auto-init completion left a request");
    eop_mask_a: assert property ((eop_evt[1] && !i_auto_init[1] && !cmd_mclr) |=> mask[1])
        else $error("end-of-process did not mask channel");
    single_mask_a: assert property ((wr_mask && !done[1] && i_io_wdata[BIT_CH_SEL]
        && !cmd_mclr) |=> mask[1] == $past(i_io_wdata[BIT_SET]))
        else $error("single mask write lost");
    group_read_a: assert property ((i_io_rd && i_io_addr == ADDR_GRP_MASK)
        |=> o_io_rdata == {6'h00, $past(mask)})
        else $error("group mask read mismatch");
    masked_soft_a: assert property ((mask[0] and s_soft_wr0) |=> o_soft_request[0]
        && !o_hw_request[0])
        else $error("masked channel lost software request");
    width_write_a: assert property ((wr_width && !i_io_wdata[BIT_CH_SEL] && !cmd_mclr)
        |=> o_req_width_8[0] == $past(i_io_wdata[BIT_REQ_W])
        && o_tgt_width_8[0] == $past(i_io_wdata[BIT_TGT_W]))
        else $error("bus width write lost");
    irq_gate_a: assert property ((done[0] && !irq_en_q[0] && !done_st[0]) |=> !done_st[0])
        else $error("completion status set while disabled");
    chain_irq_a: assert property ((i_chain_need[1] && o_chain_en[1] && !cmd_mclr && !wr_chain)
        |=> chain_st[1] && o_dma_irq_out)
        else $error("chaining interrupt not raised");
    chain_clear_a: assert property ((i_tgt_msb_wr[0] && !i_chain_need[0]) |=> !chain_st[0])
        else $error("chaining status not cleared");
    done_cmd_a: assert property ((cmd_done && done == 2'h0) |=> done_st == 2'h0)
        else $error("clear-done command ignored");
    master_clear_a: assert property (cmd_mclr |=> mask == RST_MASK && pending == RST_PENDING
        && irq_en_q == RST_IRQ_EN && o_chain_en == 2'h0)
        else $error("master clear incomplete");
endmodule : dmarc_ctrl

// ===== test/dmarc_periph_model.sv
// Peripheral-side model driving terminal count and end-of-process events
`timescale 1ns/1ps
module dmarc_periph_model
    import dmarc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [NUM_CH-1:0] i_tc_cmd, // Bench asks for a terminal count pulse
    input wire logic [NUM_CH-1:0] i_eop_cmd, // Bench asks for an end-of-process strobe
    output logic [NUM_CH-1:0] o_term_count, // One-cycle terminal count pulse
    output logic [NUM_CH-1:0] o_end_of_process_n // Open-drain line seen through its pull-up
);
    // ========================================
    // Event drivers
    // Pulses last one cycle; a released end-of-process line floats back high
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_term_count <= 2'h0;
            o_end_of_process_n <= 2'h3;
        end else begin
            o_term_count <= i_tc_cmd;
            o_end_of_process_n <= ~i_eop_cmd; // Low for one cycle, then pull-up level
        end
    end
endmodule : dmarc_periph_model

// ===== test/dma_request_mask_irq_control_test.sv
// Self-checking bench for the DMA request, mask and interrupt control block
`timescale 1ns/1ps
module dma_request_mask_irq_control_test
    import dmarc_pkg::*;
;
    // ========================================
    // Signals
    logic i_clk = 1'h0; // Bus clock
    logic i_reset_n = 1'h0; // Synchronous reset, active low
    logic [AW-1:0] io_addr = 16'h0000; // I/O address
    logic io_wr_en = 1'h0; // Write strobe
    logic io_rd_en = 1'h0; // Read strobe
    logic [DW-1:0] io_wdata = 8'h00; // Write data
    logic [DW-1:0] rdata; // Read data
    logic [1:0] hw_req = 2'h0, auto_init = 2'h0, need = 2'h0, tmsb = 2'h0; // Side inputs
    logic [1:0] tc_cmd = 2'h0, eop_cmd = 2'h0; // Partner commands
    logic srd = 1'h0; // Main status read pulse
    logic [1:0] tc, eop_n, hw_out, soft_out, mask_out, req8, tgt8, chain_out; // Wires
    logic bptr, mclr, irq; // Command pulses and interrupt
    int err_count = 0; // Mismatches
    int checks = 0; // Comparisons

    // Clock, 10 ns period
    always #5 i_clk = ~i_clk;

    // ========================================
    // Instances
    dmarc_ctrl dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_io_addr(io_addr),
        .i_io_wr(io_wr_en), .i_io_rd(io_rd_en), .i_io_wdata(io_wdata), .o_io_rdata(rdata),
        .i_channel_hw_request(hw_req), .i_term_count(tc), .i_end_of_process_n(eop_n),
        .i_auto_init(auto_init), .i_chain_need(need), .i_tgt_msb_wr(tmsb),
        .i_main_status_rd(srd), .o_hw_request(hw_out), .o_soft_request(soft_out),
        .o_hw_mask(mask_out), .o_req_width_8(req8), .o_tgt_width_8(tgt8),
        .o_chain_en(chain_out), .o_clear_byte_ptr(bptr), .o_master_clear(mclr),
        .o_dma_irq_out(irq));
    dmarc_periph_model periph_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tc_cmd(tc_cmd),
        .i_eop_cmd(eop_cmd), .o_term_count(tc), .o_end_of_process_n(eop_n));

    // ========================================
    // Tasks
    // Compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Single write; command pulses checked in the write cycle
    task automatic io_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic [7:0] exp;
        exp = {6'h00, (a == ADDR_MCLR) || (a == ISA_MCLR), (a == ADDR_CLR_BPTR) || (a == ISA_CLR_BPTR)};
        @(posedge i_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_en <= 1'h1;
        #1 chk("cmd", {6'h00, mclr, bptr}, exp);
        @(posedge i_clk);
        io_wr_en <= 1'h0;
        #1;
    endtask : io_wr

    // Single read; data valid the cycle after the strobe
    task automatic io_rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string name);
        @(posedge i_clk);
        io_addr <= a;
        io_rd_en <= 1'h1;
        @(posedge i_clk);
        io_rd_en <= 1'h0;
        #1 chk(name, rdata, exp);
    endtask : io_rd

    // Channel events, then let them land
    task automatic ev(input logic [1:0] t, e, n, m, input logic s);
        @(posedge i_clk);
        tc_cmd <= t;
        eop_cmd <= e;
        need <= n;
        tmsb <= m;
        srd <= s;
        @(posedge i_clk);
        {tc_cmd, eop_cmd, need, tmsb, srd} <= 9'h000;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : ev

    // Verdict and end of run
    task automatic print_verdict();
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge i_clk);
        err_count++;
        print_verdict();
    end

    // ========================================
    // Tests
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'h1;
        io_rd(ADDR_GRP_MASK, 8'h03, "grp");
        io_rd(ADDR_IRQ_EN, 8'h00, "ien");
        io_rd(ADDR_SOFT_REQ, 8'h00, "srq");
        io_rd(ADDR_CHAIN, 8'h00, "ists");
        io_rd(16'hF010, 8'h00, "unmapped");
        // Mask paths share one bit per channel
        hw_req <= 2'h3;
        io_wr(ADDR_CH_MASK, 8'h00);
        io_rd(ADDR_GRP_MASK, 8'h02, "grp");
        chk("hwreq", {6'h00, hw_out}, 8'h01);
        io_wr(ISA_CH_MASK, 8'h01);
        io_rd(ADDR_GRP_MASK, 8'h00, "grp");
        io_wr(ADDR_CH_MASK, 8'h05);
        io_rd(ADDR_GRP_MASK, 8'h02, "grp");
        io_wr(ISA_GRP_MASK, 8'h01);
        io_rd(ISA_GRP_MASK, 8'h01, "grp");
        io_wr(ADDR_CLR_MASKS, 8'hA5);
        io_rd(ADDR_GRP_MASK, 8'h00, "grp");
        // Software requests while masked, cleared by events
        io_wr(ADDR_GRP_MASK, 8'h03);
        io_wr(ADDR_SOFT_REQ, 8'h04);
        io_wr(ISA_SOFT_REQ, 8'h05);
        io_wr(ADDR_SOFT_REQ, 8'h01);
        io_rd(ADDR_SOFT_REQ, 8'h03, "srq");
        io_wr(ADDR_CLR_MASKS, 8'h00);
        ev(2'h1, 2'h0, 2'h0, 2'h0, 1'h0);
        io_rd(ADDR_SOFT_REQ, 8'h02, "srq");
        io_rd(ADDR_GRP_MASK, 8'h01, "grp");
        ev(2'h0, 2'h2, 2'h0, 2'h0, 1'h0);
        io_rd(ADDR_SOFT_REQ, 8'h00, "srq");
        io_rd(ADDR_GRP_MASK, 8'h03, "grp");
        io_wr(ADDR_CLR_MASKS, 8'h00);
        io_wr(ADDR_SOFT_REQ, 8'h04);
        io_wr(ADDR_SOFT_REQ, 8'h05);
        auto_init <= 2'h3;
        ev(2'h1, 2'h0, 2'h0, 2'h0, 1'h0);
        io_rd(ADDR_SOFT_REQ, 8'h00, "srq");
        io_rd(ADDR_GRP_MASK, 8'h00, "grp");
        auto_init <= 2'h0;
        // Bus widths
        io_wr(ADDR_BUS_WIDTH, 8'h01);
        chk("width", {4'h0, req8, tgt8}, 8'h05);
        io_wr(ADDR_BUS_WIDTH, 8'h40);
        chk("width", {4'h0, req8, tgt8}, 8'h04);
        io_wr(ADDR_BUS_WIDTH, 8'h11);
        chk("width", {4'h0, req8, tgt8}, 8'h06);
        // Completion interrupt
        io_wr(ADDR_IRQ_EN, 8'h01);
        io_rd(ADDR_IRQ_EN, 8'h01, "ien");
        ev(2'h3, 2'h0, 2'h0, 2'h0, 1'h0);
        io_rd(ADDR_CHAIN, 8'h10, "ists");
        chk("irq", {7'h00, irq}, 8'h01);
        ev(2'h0, 2'h0, 2'h0, 2'h0, 1'h1);
        io_rd(ADDR_CHAIN, 8'h00, "ists");
        ev(2'h0, 2'h1, 2'h0, 2'h0, 1'h0);
        chk("irq", {7'h00, irq}, 8'h01);
        io_wr(ADDR_CLR_DONE, 8'h3C);
        chk("irq", {7'h00, irq}, 8'h00);
        // Chaining, set up in the documented order
        io_wr(ADDR_CHAIN, 8'h05);
        chk("chain", {6'h00, chain_out}, 8'h02);
        io_wr(ADDR_CHAIN, 8'h01);
        chk("chain", {6'h00, chain_out}, 8'h00);
        io_wr(ADDR_CHAIN, 8'h04);
        io_wr(ADDR_CH_MASK, 8'h00);
        chk("chain", {6'h00, chain_out}, 8'h01);
        ev(2'h1, 2'h0, 2'h0, 2'h0, 1'h0);
        io_rd(ADDR_CHAIN, 8'h00, "ists");
        ev(2'h0, 2'h0, 2'h1, 2'h0, 1'h0);
        io_rd(ADDR_CHAIN, 8'h01, "ists");
        chk("irq", {7'h00, irq}, 8'h01);
        ev(2'h0, 2'h0, 2'h0, 2'h1, 1'h0);
        io_rd(ADDR_CHAIN, 8'h00, "ists");
        ev(2'h0, 2'h0, 2'h1, 2'h0, 1'h0);
        io_rd(ADDR_CHAIN, 8'h01, "ists");
        // Master clear restores defaults
        io_wr(ISA_CLR_BPTR, 8'h00);
        io_wr(ADDR_MCLR, 8'hFF);
        io_rd(ADDR_GRP_MASK, 8'h03, "grp");
        io_rd(ADDR_IRQ_EN, 8'h00, "ien");
        io_rd(ADDR_CHAIN, 8'h00, "ists");
        chk("defaults", {req8, tgt8, chain_out, irq, 1'h0}, 8'hF0);
        print_verdict();
    end
endmodule : dma_request_mask_irq_control_test
